// ===== design/normal_mode_command_handler.sv
// Normal-mode command handler: datagram slot scheduling and mode entry
`timescale 1ns/10ps
`default_nettype none
`include "nm_cmd_params.svh"

module normal_mode_command_handler #(
  parameter int DG_TIME_CYCLES = (`DG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  // Received characters from the serial receiver
  input  wire logic                 i_rx_valid,
  input  wire logic [7:0]           i_rx_data,
  // Configuration of this unit
  input  wire logic [7:0]           i_module_identifier,
  input  wire logic                 i_ext_trig_mode,
  // Datagram timing
  input  wire logic                 i_ext_trig,
  input  wire logic                 i_sample_tick,
  input  wire logic                 i_tx_busy,
  input  wire logic                 i_tx_done,
  // Configuration mode exits
  input  wire logic                 i_config_exit,
  input  wire logic                 i_peer_exit,
  // Datagram requests to the transmitter
  output var nm_cmd_pkg::dg_start_t o_dg,
  output var logic                  o_meas_skip,
  // Unit control
  output var logic                  o_err_clear,
  output var logic                  o_unit_reset,
  output var logic                  o_enter_terminal_config,
  output var logic                  o_listing_req,
  output var logic                  o_config_mode,
  output var logic                  o_silenced
);
  import nm_cmd_pkg::*;

  localparam int CNT_W = $clog2(DG_TIME_CYCLES + 1);

  if (DG_TIME_CYCLES < 1) begin : g_bad_time
    $error("DG_TIME_CYCLES must be at least one");
  end

  cmd_t             cmd;
  mode_t            mode_q;
  logic             addr_q;
  logic [CNT_W-1:0] dly_cnt_q;
  logic [CNT_W-1:0] dly_seen_q;
  logic             trig_s1_q;
  logic             trig_s2_q;
  logic             trig_s3_q;
  logic             trig_edge;
  logic             slot;
  logic             pend_q;
  dg_kind_t         pend_kind_q;
  logic             req_new;
  dg_kind_t         req_kind;
  logic             take;
  dg_kind_t         inflight_q;

  cmd_line_parser u_parser (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_rx_valid(i_rx_valid),
    .i_rx_data (i_rx_data),
    .i_enable  (mode_q == MD_NORMAL),
    .o_cmd     (cmd)
  );

  // Trigger pin is asynchronous; the third stage only feeds the edge detector
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= i_ext_trig;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  assign trig_edge = trig_s2_q && !trig_s3_q;
  assign slot      = i_ext_trig_mode ? trig_edge : i_sample_tick; // R04

  // Special datagram letters map onto the transmitter's datagram kinds
  always_comb begin
    req_new  = 1'b0;
    req_kind = DG_MEAS;
    if (cmd.valid && mode_q == MD_NORMAL) begin
      req_new = 1'b1;
      case (cmd.kind)
        CMD_SERIAL: req_kind = DG_SERIAL; // R01
        CMD_CONFIG: req_kind = DG_CONFIG; // R05
        CMD_TRIM:   req_kind = DG_TRIM; // R06
        CMD_ERROR:  req_kind = DG_ERROR; // R07
        default:    req_new  = 1'b0;
      endcase
    end
  end

  assign take = (mode_q == MD_NORMAL) && slot && !i_tx_busy && pend_q;

  // A second request while one waits is dropped; consuming and requesting
  // in the same cycle keeps the new one
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pend_q      <= 1'b0;
      pend_kind_q <= DG_MEAS;
    end else begin
      if (take) begin
        pend_q <= 1'b0; // R25
      end
      if (req_new && (!pend_q || take)) begin // R25
        pend_q      <= 1'b1;
        pend_kind_q <= req_kind;
      end
    end
  end

  // Special datagrams replace a slot rather than adding one
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_dg        <= '0;
      o_meas_skip <= 1'b0;
    end else begin
      o_dg.go     <= 1'b0;
      o_meas_skip <= 1'b0;
      if (mode_q == MD_NORMAL && slot) begin
        if (i_tx_busy) begin
          o_meas_skip <= 1'b1; // R03
        end else begin
          o_dg.go   <= 1'b1; // R02
          o_dg.kind <= pend_q ? pend_kind_q : DG_MEAS; // R02
        end
      end
    end
  end

  // The error record is cleared only after the whole datagram has gone out
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      inflight_q  <= DG_MEAS;
      o_err_clear <= 1'b0;
    end else begin
      o_err_clear <= i_tx_done && (inflight_q == DG_ERROR); // R08
      if (o_dg.go) begin
        inflight_q <= o_dg.kind;
      end else if (i_tx_done) begin
        inflight_q <= DG_MEAS;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_unit_reset <= 1'b0;
    end else begin
      o_unit_reset <= cmd.valid && (cmd.kind == CMD_RESET) && (mode_q == MD_NORMAL); // R09
    end
  end

  // Mode entry: a foreign address silences this unit; otherwise drain,
  // optionally wait one datagram time, then enter configuration mode
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mode_q                  <= MD_NORMAL;
      addr_q                  <= 1'b0;
      dly_cnt_q               <= '0;
      o_enter_terminal_config <= 1'b0;
      o_listing_req           <= 1'b0;
    end else begin
      o_enter_terminal_config <= 1'b0;
      o_listing_req           <= 1'b0;
      case (mode_q)
        MD_NORMAL: begin
          if (cmd.valid && cmd.kind == CMD_ENTRY) begin // R10 R17
            addr_q <= cmd.addressed;
            if (cmd.addressed && cmd.id != i_module_identifier) begin
              mode_q <= MD_SILENT; // R15
            end else begin
              mode_q <= MD_DRAIN;
            end
          end
        end
        MD_DRAIN: begin
          if (!i_tx_busy) begin // R12
            if (addr_q) begin
              mode_q    <= MD_DELAY; // R13
              dly_cnt_q <= CNT_W'(DG_TIME_CYCLES - 1);
            end else begin
              mode_q                  <= MD_CONFIG;
              o_enter_terminal_config <= 1'b1;
              o_listing_req           <= 1'b1; // R19
            end
          end
        end
        MD_DELAY: begin
          if (dly_cnt_q == '0) begin
            mode_q                  <= MD_CONFIG;
            o_enter_terminal_config <= 1'b1;
            o_listing_req           <= 1'b1; // R19
          end else begin
            dly_cnt_q <= dly_cnt_q - CNT_W'(1);
          end
        end
        MD_CONFIG: begin
          // Answers in this mode come from the terminal side with no added delay
          if (i_config_exit) begin // R14
            mode_q <= MD_NORMAL;
            addr_q <= 1'b0;
          end
        end
        MD_SILENT: begin
          if (i_peer_exit) begin
            mode_q <= MD_NORMAL; // R16
            addr_q <= 1'b0;
          end
        end
        default: mode_q <= MD_NORMAL;
      endcase
    end
  end

  assign o_config_mode = (mode_q == MD_CONFIG);
  assign o_silenced    = (mode_q == MD_SILENT);

  // Helper for checking the length of the addressed entry delay
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || mode_q == MD_NORMAL) begin
      dly_seen_q <= '0;
    end else if (mode_q == MD_DELAY && dly_seen_q != '1) begin
      dly_seen_q <= dly_seen_q + CNT_W'(1);
    end
  end

  slot_replace_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R02
    (mode_q == MD_NORMAL && slot && !i_tx_busy && pend_q)
      |=> (o_dg.go && o_dg.kind == $past(pend_kind_q)))
    else $error("pending special datagram did not take the slot");

  busy_skip_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R03
    (mode_q == MD_NORMAL && slot && i_tx_busy) |=> (o_meas_skip && !o_dg.go))
    else $error("slot during transmission was not suppressed");

  trig_only_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R04
    (i_ext_trig_mode && !trig_edge) |=> !o_dg.go)
    else $error("datagram started without a trigger");

  serial_once_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R01
    (o_dg.go && o_dg.kind == DG_SERIAL) |-> (!pend_q || $past(req_new)))
    else $error("serial request served twice");

  err_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R08
    o_err_clear |-> $past(i_tx_done && inflight_q == DG_ERROR))
    else $error("error record cleared without error datagram end");

  reset_cmd_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R09
    (cmd.valid && cmd.kind == CMD_RESET && mode_q == MD_NORMAL) |=> o_unit_reset)
    else $error("reset command did not reset the unit");

  drain_first_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R12
    (mode_q == MD_DRAIN && i_tx_busy) |=> (!o_enter_terminal_config && mode_q == MD_DRAIN))
    else $error("configuration mode entered during a datagram");

  addr_delay_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R13
    (o_enter_terminal_config && addr_q) |-> dly_seen_q == CNT_W'(DG_TIME_CYCLES))
    else $error("addressed entry delay has the wrong length");

  silent_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R15
    (mode_q == MD_SILENT && !i_peer_exit) |=> (!o_dg.go && !o_unit_reset && o_silenced))
    else $error("silenced unit transmitted or acted");

  peer_exit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R16
    (mode_q == MD_SILENT && i_peer_exit)
      |=> (mode_q == MD_NORMAL) ##1 (!o_enter_terminal_config && !o_listing_req))
    else $error("peer exit not followed by quiet resume");

  listing_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R19
    o_enter_terminal_config |-> (o_listing_req && mode_q == MD_CONFIG))
    else $error("mode entry without configuration listing");

endmodule
`default_nettype wire

// ===== design/nm_cmd_params.svh
// Constants for the normal-mode command handler
// Overview of operation
// R01 - Serial-number letter then line end sends exactly one serial-number datagram.
// R02 - A requested special datagram takes the next measurement slot, never inserted between.
// R03 - A long special datagram may suppress several following measurement datagrams.
// R04 - In external trigger mode the special datagram waits for the next trigger.
// R05 - Configuration letter then line end sends exactly one configuration datagram.
// R06 - Bias-trim letter then line end sends exactly one bias trim offset datagram.
// R07 - Extended-error letter then line end sends one accumulated-error datagram.
// R08 - The accumulated error record is cleared once that datagram is fully sent.
// R09 - Reset letter then line end forces a full unit reset.
// R10 - Mode-entry word is accepted alone or with separator and module identifier.
// R11 - Identifier is an integer; outside 0 to 255 the command is silently dropped.
// R12 - A datagram in flight is finished before configuration mode is entered.
// R13 - The addressed, matching unit delays its response by one datagram time.
// R14 - Once in configuration mode, later answers carry no extra delay.
// R15 - A non-matching unit stops datagrams and ignores commands until peer exits.
// R16 - On the peer's exit, non-matching units resume measurements with no reply.
// R17 - The unaddressed entry form still works in multi-module transmission.
// R18 - The host should avoid the unaddressed entry form on a shared line.
// R19 - On entering configuration mode the unit lists its configuration data.
// R20 - The host sends every command of this set in upper case.
// R21 - Line end 0x0d terminates and triggers execution of each command.
// R22 - Separator 0x20 divides the command word from its first parameter.
// R23 - No echo and no error replies; act only on a complete, correct command.
// R24 - Characters collect until line end; unmatched sequences are dropped without effect.
// R25 - One special request pends at a time; it is consumed when its datagram starts.
`ifndef NM_CMD_PARAMS_SVH
`define NM_CMD_PARAMS_SVH

`define CHAR_LINE_END   8'h0d
`define CHAR_SEPARATOR  8'h20
`define CHAR_DIGIT_0    8'h30
`define CHAR_DIGIT_9    8'h39
`define CHAR_SERIAL     8'h49
`define CHAR_CONFIG     8'h43
`define CHAR_TRIM       8'h54
`define CHAR_ERROR      8'h45
`define CHAR_RESET      8'h52
`define ENTRY_LEN       11
`define ENTRY_WORD      88'h53_45_52_56_49_43_45_4d_4f_44_45
`define ID_MAX          255
`define CLK_PERIOD_NS   8
`define DG_TIME_NS      100000

`endif

// ===== design/nm_cmd_pkg.sv
// Types shared by the normal-mode command handler files
package nm_cmd_pkg;

  typedef enum logic [2:0] {
    CMD_SERIAL,
    CMD_CONFIG,
    CMD_TRIM,
    CMD_ERROR,
    CMD_RESET,
    CMD_ENTRY
  } cmd_kind_t;

  typedef struct packed {
    logic      valid;
    cmd_kind_t kind;
    logic      addressed;
    logic [7:0] id;
  } cmd_t;

  typedef enum logic [2:0] {
    DG_MEAS,
    DG_SERIAL,
    DG_CONFIG,
    DG_TRIM,
    DG_ERROR
  } dg_kind_t;

  typedef struct packed {
    logic     go;
    dg_kind_t kind;
  } dg_start_t;

  typedef enum logic [2:0] {
    MD_NORMAL,
    MD_DRAIN,
    MD_DELAY,
    MD_CONFIG,
    MD_SILENT
  } mode_t;

endpackage

// ===== design/cmd_line_parser.sv
// Collects received characters into one decoded normal-mode command
`timescale 1ns/10ps
`default_nettype none
`include "nm_cmd_params.svh"

module cmd_line_parser (
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Received characters
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_enable,
  // Decoded command
  output var nm_cmd_pkg::cmd_t o_cmd
);
  import nm_cmd_pkg::*;

  localparam logic [8*`ENTRY_LEN-1:0] ENTRY_WORD = `ENTRY_WORD;
  localparam logic [4:0]              LEN        = 5'(`ENTRY_LEN);

  logic [4:0]  pos_q;
  logic [7:0]  first_q;
  logic        word_ok_q;
  logic        sep_ok_q;
  logic        digits_q;
  logic        bad_q;
  logic [7:0]  val_q;
  logic [7:0]  ref_char;
  logic        is_digit;
  logic        is_end;
  logic [11:0] next_val;
  cmd_t        cmd_d;

  assign is_end   = i_rx_valid && (i_rx_data == `CHAR_LINE_END); // R21
  assign is_digit = (i_rx_data >= `CHAR_DIGIT_0) && (i_rx_data <= `CHAR_DIGIT_9);
  assign next_val = {4'h0, val_q} * 12'd10 + {8'h00, i_rx_data[3:0]};

  always_comb begin
    ref_char = 8'h00;
    if (pos_q < LEN) begin
      ref_char = ENTRY_WORD[8*(`ENTRY_LEN - 1 - int'(pos_q)) +: 8];
    end
  end

  // Lines longer than the position counter saturate it at 31; only an addressed entry with leading zeros can then still match
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_enable || is_end) begin
      pos_q     <= 5'h00;
      first_q   <= 8'h00;
      word_ok_q <= 1'b1;
      sep_ok_q  <= 1'b0;
      digits_q  <= 1'b0;
      bad_q     <= 1'b0;
      val_q     <= 8'h00;
    end else if (i_rx_valid) begin // R24
      if (pos_q != 5'h1f) begin
        pos_q <= pos_q + 5'h01;
      end
      if (pos_q == 5'h00) begin
        first_q <= i_rx_data;
      end
      if (pos_q < LEN) begin
        word_ok_q <= word_ok_q && (i_rx_data == ref_char);
      end else if (pos_q == LEN) begin
        sep_ok_q <= word_ok_q && (i_rx_data == `CHAR_SEPARATOR); // R22
      end else if (is_digit && !bad_q) begin
        digits_q <= 1'b1;
        if (next_val > 12'(`ID_MAX)) begin
          bad_q <= 1'b1; // R11
        end else begin
          val_q <= next_val[7:0];
        end
      end else begin
        bad_q <= 1'b1; // R11
      end
    end
  end

  always_comb begin
    cmd_d = '0;
    if (is_end && i_enable) begin // R23
      if (pos_q == 5'h01) begin
        cmd_d.valid = 1'b1;
        case (first_q)
          `CHAR_SERIAL: cmd_d.kind = CMD_SERIAL; // R01
          `CHAR_CONFIG: cmd_d.kind = CMD_CONFIG; // R05
          `CHAR_TRIM:   cmd_d.kind = CMD_TRIM; // R06
          `CHAR_ERROR:  cmd_d.kind = CMD_ERROR; // R07
          `CHAR_RESET:  cmd_d.kind = CMD_RESET; // R09
          default:      cmd_d.valid = 1'b0; // R24
        endcase
      end else if (pos_q == LEN && word_ok_q) begin // R10
        cmd_d.valid = 1'b1;
        cmd_d.kind  = CMD_ENTRY;
      end else if (pos_q > LEN + 5'h01 && sep_ok_q && digits_q && !bad_q) begin // R10
        cmd_d.valid     = 1'b1;
        cmd_d.kind      = CMD_ENTRY;
        cmd_d.addressed = 1'b1;
        cmd_d.id        = val_q;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_cmd <= '0;
    end else begin
      o_cmd <= cmd_d;
    end
  end

  id_range_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R11
    (is_end && bad_q) |=> !o_cmd.valid)
    else $error("out-of-range identifier was not discarded");

  empty_line_a: assert property (@(posedge i_clk_sys) disable iff (i_rst) // R24
    (is_end && pos_q == 5'h00) |=> !o_cmd.valid)
    else $error("empty line produced a command");

endmodule
`default_nettype wire

// ===== verification/tx_model.sv
// Transmitter stand-in: busy for one datagram length after each start pulse
`timescale 1ns/10ps
`default_nettype none

module tx_model #(
  parameter int MEAS_LEN    = 24,
  parameter int SPECIAL_LEN = 40
) (
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  // Datagram start from the handler
  input  wire nm_cmd_pkg::dg_start_t i_dg,
  // Transmitter status
  output var logic                  o_tx_busy,
  output var logic                  o_tx_done
);
  import nm_cmd_pkg::*;

  int cnt;

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_tx_busy <= 1'b0;
      o_tx_done <= 1'b0;
      cnt       <= 0;
    end else begin
      o_tx_done <= 1'b0;
      if (i_dg.go === 1'b1) begin
        o_tx_busy <= 1'b1;
        // Specials outlast measurements so a later slot lands inside one
        cnt <= (i_dg.kind == DG_MEAS) ? MEAS_LEN : SPECIAL_LEN;
      end else if (o_tx_busy) begin
        if (cnt <= 1) begin
          o_tx_busy <= 1'b0;
          o_tx_done <= 1'b1;
        end
        cnt <= cnt - 1;
      end
    end
  end
endmodule

`default_nettype wire

// ===== verification/normal_mode_command_handler_test.sv
// Self-checking bench for the normal-mode command handler
`timescale 1ns/10ps
`default_nettype none
`include "nm_cmd_params.svh"

module normal_mode_command_handler_test;
  import nm_cmd_pkg::*;

  localparam int DG_T = 20;
  localparam logic [7:0] EV_SKIP  = 8'h40;
  localparam logic [7:0] EV_ERRC  = 8'h20;
  localparam logic [7:0] EV_RST   = 8'h10;
  localparam logic [7:0] EV_ENTER = 8'h08;

  logic       i_clk_sys = 1'b0;
  logic       i_rst = 1'b1;
  logic       i_rx_valid = 1'b0;
  logic [7:0] i_rx_data = 8'h00;
  logic [7:0] i_module_identifier = 8'h00;
  logic       i_ext_trig_mode = 1'b0;
  logic       i_ext_trig = 1'b0;
  logic       i_sample_tick = 1'b0;
  logic       i_config_exit = 1'b0;
  logic       i_peer_exit = 1'b0;
  logic       i_tx_busy;
  logic       i_tx_done;
  dg_start_t  o_dg;
  logic       o_meas_skip;
  logic       o_err_clear;
  logic       o_unit_reset;
  logic       o_enter_terminal_config;
  logic       o_listing_req;
  logic       o_config_mode;
  logic       o_silenced;
  logic [7:0] exp_q[$];
  logic [7:0] ev;
  logic [7:0] ids[3];
  int         n_fail = 0;
  int         check_count = 0;
  int         seed = 32'h88a2;
  string      ltr[4] = '{"I", "C", "T", "E"};
  dg_kind_t   kd[4] = '{DG_SERIAL, DG_CONFIG, DG_TRIM, DG_ERROR};
  string      wrd;
  string      bad[8];

  initial begin
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  normal_mode_command_handler #(.DG_TIME_CYCLES(DG_T)) dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
    .i_module_identifier(i_module_identifier), .i_ext_trig_mode(i_ext_trig_mode),
    .i_ext_trig(i_ext_trig), .i_sample_tick(i_sample_tick), .i_tx_busy(i_tx_busy),
    .i_tx_done(i_tx_done), .i_config_exit(i_config_exit), .i_peer_exit(i_peer_exit),
    .o_dg(o_dg), .o_meas_skip(o_meas_skip), .o_err_clear(o_err_clear),
    .o_unit_reset(o_unit_reset), .o_enter_terminal_config(o_enter_terminal_config),
    .o_listing_req(o_listing_req), .o_config_mode(o_config_mode), .o_silenced(o_silenced));

  tx_model xmit (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_dg(o_dg),
    .o_tx_busy(i_tx_busy), .o_tx_done(i_tx_done));

  function automatic logic [7:0] ev_go(input dg_kind_t k);
    return {5'b10000, k};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  // Host side: text as given (upper or lower case), then line end; characters back to back
  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) begin
      i_rx_valid = 1'b1;
      i_rx_data  = s[i];
      step(1);
    end
    i_rx_valid = 1'b1;
    i_rx_data  = 8'h0d;
    step(1);
    i_rx_valid = 1'b0;
  endtask

  task automatic tick(input logic [7:0] e, input logic want);
    if (want)
      exp_q.push_back(e);
    i_sample_tick = 1'b1;
    step(1);
    i_sample_tick = 1'b0;
  endtask

  task automatic settle;
    int i;
    for (i = 0; i < 400 && (exp_q.size() != 0 || i_tx_busy !== 1'b0); i++)
      step(1);
    if (i == 400) begin
      n_fail++;
      $display("Error at %0t: wait expired", $time);
      end_sim();
    end
  endtask

  // Addressed entry for a matching unit, timed from the line end
  task automatic enter_at(input logic [7:0] v);
    int n;
    i_module_identifier = v;
    exp_q.push_back(EV_ENTER);
    send_line({wrd, $sformatf(" %0d", v)});
    for (n = 0; n < 200 && o_enter_terminal_config !== 1'b1; n++)
      @(negedge i_clk_sys);
    check(n >= DG_T && n <= DG_T + 6, 1);
    if (n == 200)
      end_sim();
    check(o_config_mode, 1);
    step(1);
    i_config_exit = 1'b1;
    step(1);
    i_config_exit = 1'b0;
    step(2);
    check(o_config_mode, 0);
  endtask

  // Every output event must match the oldest expectation
  always @(negedge i_clk_sys) begin
    ev = {o_dg.go, o_meas_skip, o_err_clear, o_unit_reset, o_enter_terminal_config,
          o_dg.go ? o_dg.kind : 3'h0};
    if (ev !== 8'h00) begin
      if (exp_q.size() == 0)
        check(ev, 8'h00);
      else
        check(ev, exp_q.pop_front());
      if (o_enter_terminal_config === 1'b1) begin
        check(o_listing_req, 1);
        check(i_tx_busy, 0);
      end
    end
  end

  initial begin
    ids[0] = 8'h00;
    ids[1] = 8'hff;
    ids[2] = 8'($random(seed));
    // Entry word text is built from the same constant the parser matches
    wrd = $sformatf("%s", `ENTRY_WORD);
    bad = '{"i", "X", {wrd, " 256"}, {wrd, " "}, {wrd, " 1A"}, wrd.tolower(),
            wrd.substr(0, 9), "II"};
    step(4);
    i_rst = 1'b0;
    step(3);
    tick(ev_go(DG_MEAS), 1);
    settle();
    for (int k = 0; k < 4; k++) begin
      send_line(ltr[k]);
      step(4);
      tick(ev_go(kd[k]), 1);
      if (kd[k] == DG_ERROR)
        exp_q.push_back(EV_ERRC);
      settle();
      tick(ev_go(DG_MEAS), 1);
      settle();
    end
    // Second request while one pends is dropped; slot during a special is skipped
    send_line("I");
    step(1);
    send_line("C");
    step(4);
    tick(ev_go(DG_SERIAL), 1);
    step(5);
    tick(EV_SKIP, 1);
    settle();
    tick(ev_go(DG_MEAS), 1);
    settle();
    foreach (bad[i]) begin
      send_line(bad[i]);
      step(3);
    end
    tick(ev_go(DG_MEAS), 1);
    settle();
    i_ext_trig_mode = 1'b1;
    send_line("T");
    step(4);
    tick(8'h00, 0);
    step(4);
    exp_q.push_back(ev_go(DG_TRIM));
    i_ext_trig = 1'b1;
    step(3);
    i_ext_trig = 1'b0;
    settle();
    i_ext_trig_mode = 1'b0;
    exp_q.push_back(EV_RST);
    send_line("R");
    settle();
    // Single unit on the line, so the unaddressed form is used here
    tick(ev_go(DG_MEAS), 1);
    step(2);
    exp_q.push_back(EV_ENTER);
    send_line(wrd);
    settle();
    check(o_config_mode, 1);
    tick(8'h00, 0);
    send_line("I");
    step(4);
    i_config_exit = 1'b1;
    step(1);
    i_config_exit = 1'b0;
    step(2);
    tick(ev_go(DG_MEAS), 1);
    settle();
    foreach (ids[i])
      enter_at(ids[i]);
    send_line({wrd, $sformatf(" %0d", ids[2] ^ 8'h5a)});
    step(3);
    check(o_silenced, 1);
    tick(8'h00, 0);
    send_line("R");
    step(4);
    i_peer_exit = 1'b1;
    step(1);
    i_peer_exit = 1'b0;
    step(3);
    check(o_silenced, 0);
    tick(ev_go(DG_MEAS), 1);
    settle();
    check(exp_q.size(), 0);
    end_sim();
  end
endmodule

`default_nettype wire
